/* eeprom_ctrl_map.vh */
// register map, command codes and timing counts for the parallel eeprom controller
`ifndef EEPROM_CTRL_MAP_VH
`define EEPROM_CTRL_MAP_VH

// register byte offsets
`define REG_CMD       4'h0
`define REG_ADDR      4'h4
`define REG_WDATA     4'h8
`define REG_STATUS    4'hc

// command codes written to the command register
`define CMD_READ      3'h1
`define CMD_WRITE     3'h2
`define CMD_COMMIT    3'h3
`define CMD_PROT_ON   3'h4
`define CMD_PROT_OFF  3'h5

// status register fields
`define ST_BUSY       0
`define ST_PAGEOPEN   1
`define ST_RDY_PIN    2
`define ST_TOGGLE     3
`define ST_RDATA_LSB  8

// timing in ns, clock period in ns
`define CLK_PERIOD_NS        50
`define STROBE_NS            200
`define PAGE_BYTE_INTERVAL_NS 100000
`define WRITE_CYCLE_NS       3000000
`define STROBE_CYC           ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INTERVAL_CYC         (`PAGE_BYTE_INTERVAL_NS / `CLK_PERIOD_NS)
`define WRITE_CYCLE_CYC      (`WRITE_CYCLE_NS / `CLK_PERIOD_NS)

// protection command bytes (customary jedec sequence for 8k parts)
`define SEQ_A1   13'h1555
`define SEQ_A2   13'h0aaa
`define SEQ_D1   8'haa
`define SEQ_D2   8'h55
`define SEQ_ON   8'ha0
`define SEQ_OFF1 8'h80
`define SEQ_OFF6 8'h20

`endif

/* eeprom_host.v */
// host controller driving a parallel eeprom through its pins, commanded over ahb-lite
`timescale 1ns/1ns
`include "eeprom_ctrl_map.vh"

module eeprom_host #(
   parameter INTERVAL_CYC  = `INTERVAL_CYC,
   parameter WRITE_CYC     = `WRITE_CYCLE_CYC,
   parameter STROBE_CYC    = `STROBE_CYC
)(
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   output reg  [12:0] mem_addr,
   output reg  [7:0]  dq_out,
   output reg         dq_oe,
   input  wire [7:0]  dq_in,
   output reg         chip_en_n,
   output reg         out_en_n,
   output reg         write_en_n,
   input  wire        ready_busy_od
);

   localparam ST_IDLE   = 3'd0;
   localparam ST_SETUP  = 3'd1;
   localparam ST_STROBE = 3'd2;
   localparam ST_HOLD   = 3'd3;
   localparam ST_PROG   = 3'd4;

   reg [2:0]  state;
   reg [2:0]  op;
   reg [12:0] addr_reg;
   reg [7:0]  wdata_reg;
   reg [7:0]  rdata;
   reg        page_open;
   reg [12:6] page_base;
   reg [2:0]  seq_idx;
   reg [2:0]  seq_len;
   reg [23:0] timer;
   reg [7:0]  strobe_cnt;
   reg        last_toggle, seen_low;
   reg        wr_pend;
   reg [3:0]  wr_addr;
   reg [7:0]  dq_s1, dq_s2;
   reg        rb_s1, rb_s2;

   // protection sequence address and data lookup
   function [20:0] seq_step;
      input       off;
      input [2:0] i;
      begin
         case (i)
            3'd0:    seq_step = {`SEQ_A1, `SEQ_D1};
            3'd1:    seq_step = {`SEQ_A2, `SEQ_D2};
            3'd2:    seq_step = {`SEQ_A1, off ? `SEQ_OFF1 : `SEQ_ON};
            3'd3:    seq_step = {`SEQ_A1, `SEQ_D1};
            3'd4:    seq_step = {`SEQ_A2, `SEQ_D2};
            default: seq_step = {`SEQ_A1, `SEQ_OFF6};
         endcase
      end
   endfunction

   // pin input synchronisers
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dq_s1 <= 8'h00;
         dq_s2 <= 8'h00;
         rb_s1 <= 1'b1;
         rb_s2 <= 1'b1;
      end
      else
      begin
         dq_s1 <= dq_in;
         dq_s2 <= dq_s1;
         rb_s1 <= ready_busy_od;
         rb_s2 <= rb_s1;
      end
   end

   wire busy = (state != ST_IDLE);
   wire new_page = !page_open || (addr_reg[12:6] != page_base);
   wire [20:0] step = seq_step(op == `CMD_PROT_OFF, seq_idx);

   // ahb-lite slave and pin sequencer
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hrdata      <= 32'h00000000;
         hreadyout   <= 1'b1;
         hresp       <= 1'b0;
         state       <= ST_IDLE;
         op          <= 3'h0;
         addr_reg    <= 13'h0000;
         wdata_reg   <= 8'h00;
         rdata       <= 8'h00;
         page_open   <= 1'b0;
         page_base   <= 7'h00;
         seq_idx     <= 3'h0;
         seq_len     <= 3'h0;
         timer       <= 24'h000000;
         strobe_cnt  <= 8'h00;
         last_toggle <= 1'b0;
         seen_low    <= 1'b0;
         wr_pend     <= 1'b0;
         wr_addr     <= 4'h0;
         mem_addr    <= 13'h0000;
         dq_out      <= 8'h00;
         dq_oe       <= 1'b0;
         chip_en_n   <= 1'b1;
         out_en_n    <= 1'b1;
         write_en_n  <= 1'b1;
      end
      else
      begin
         // address phase capture
         if (hready && hsel && htrans[1])
         begin
            wr_pend <= hwrite;
            wr_addr <= haddr[3:0];
            if (!hwrite)
            begin
               if (haddr[3:0] == `REG_ADDR)
                  hrdata <= {19'h00000, addr_reg};
               else if (haddr[3:0] == `REG_WDATA)
                  hrdata <= {24'h000000, wdata_reg};
               else if (haddr[3:0] == `REG_STATUS)
                  hrdata <= {16'h0000, rdata, 4'h0, last_toggle, rb_s2, page_open, busy};
               else
                  hrdata <= 32'h00000000;
            end
         end
         else
            wr_pend <= 1'b0;
         // data phase of a write
         if (wr_pend)
         begin
            if (wr_addr == `REG_ADDR)
               addr_reg <= hwdata[12:0];
            else if (wr_addr == `REG_WDATA)
               wdata_reg <= hwdata[7:0];
            else if (wr_addr == `REG_CMD && !busy)
            begin
               op <= hwdata[2:0];
               seq_idx <= 3'h0;
               if (hwdata[2:0] == `CMD_PROT_ON)
                  seq_len <= 3'd2;
               else if (hwdata[2:0] == `CMD_PROT_OFF)
                  seq_len <= 3'd5;
               else
                  seq_len <= 3'd0;
               if (hwdata[2:0] == `CMD_COMMIT)
               begin
                  state <= page_open ? ST_PROG : ST_IDLE;
                  timer <= 24'h000000;
                  page_open <= 1'b0;
               end
               else if (hwdata[2:0] == `CMD_WRITE && page_open && new_page)
               begin
                  // different page: program the open page, this write is not issued
                  state <= ST_PROG;
                  timer <= 24'h000000;
                  page_open <= 1'b0;
               end
               else if (hwdata[2:0] != 3'h0 && hwdata[2:0] <= `CMD_PROT_OFF)
                  state <= ST_SETUP;
            end
         end

         // page load window timer while idle
         if (state == ST_IDLE && page_open && !(wr_pend && wr_addr == `REG_CMD))
         begin
            if (timer >= INTERVAL_CYC[23:0] - 24'd1)
            begin
               page_open <= 1'b0;
               state <= ST_PROG;
               timer <= 24'h000000;
            end
            else
               timer <= timer + 24'd1;
         end

         case (state)
            ST_SETUP:
            begin
               chip_en_n <= 1'b0;
               strobe_cnt <= 8'h00;
               if (op == `CMD_READ)
               begin
                  mem_addr <= addr_reg;
                  dq_oe <= 1'b0;
                  out_en_n <= 1'b0;
               end
               else
               begin
                  out_en_n <= 1'b1;
                  dq_oe <= 1'b1;
                  if (op == `CMD_WRITE)
                  begin
                     mem_addr <= addr_reg;
                     dq_out <= wdata_reg;
                  end
                  else
                  begin
                     mem_addr <= step[20:8];
                     dq_out <= step[7:0];
                  end
               end
               state <= ST_STROBE;
            end
            ST_STROBE:
            begin
               if (op != `CMD_READ)
                  write_en_n <= 1'b0;
               if (strobe_cnt >= STROBE_CYC[7:0] + 8'd2)
               begin
                  if (op == `CMD_READ)
                  begin
                     rdata <= dq_s2;
                     last_toggle <= dq_s2[6];
                  end
                  write_en_n <= 1'b1;
                  out_en_n <= 1'b1;
                  state <= ST_HOLD;
               end
               else
                  strobe_cnt <= strobe_cnt + 8'd1;
            end
            ST_HOLD:
            begin
               chip_en_n <= 1'b1;
               dq_oe <= 1'b0;
               timer <= 24'h000000;
               if (op == `CMD_READ)
                  state <= ST_IDLE;
               else if (op == `CMD_WRITE)
               begin
                  page_open <= 1'b1;
                  page_base <= addr_reg[12:6];
                  state <= ST_IDLE;
               end
               else if (seq_idx != seq_len)
               begin
                  seq_idx <= seq_idx + 3'd1;
                  state <= ST_SETUP;
               end
               else
               begin
                  page_open <= 1'b1;
                  state <= ST_IDLE;
               end
            end
            ST_PROG:
            begin
               // device goes busy only after its own page window: see low, then high
               seen_low <= seen_low | !rb_s2;
               if ((seen_low && rb_s2) || timer >= WRITE_CYC[23:0] + INTERVAL_CYC[23:0])
                  state <= ST_IDLE;
               else
                  timer <= timer + 24'd1;
            end
            default: seen_low <= 1'b0;           // idle forgets the busy sighting
         endcase
      end
   end

endmodule

/* eeprom_host_props.sv */
// assertion checker for the eeprom host pins and bus answer
`timescale 1ns/1ns
module eeprom_host_props #(
   parameter STROBE_CYC = 4
)(
   input wire        hclk,
   input wire        hresetn,
   input wire        hreadyout,
   input wire        hresp,
   input wire [12:0] mem_addr,
   input wire [7:0]  dq_out,
   input wire        dq_oe,
   input wire        chip_en_n,
   input wire        out_en_n,
   input wire        write_en_n,
   input wire        ready_busy_od
);
   reg [7:0] wl;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // length of the current write strobe
   always @(posedge hclk or negedge hresetn)
      if (!hresetn)
         wl <= 8'h00;
      else
         wl <= write_en_n ? 8'h00 : wl + 8'h01;
   property p_wmode; !write_en_n |-> out_en_n && !chip_en_n && dq_oe; endproperty
   a_wmode: assert property (p_wmode) else $error("strobe outside write mode");
   property p_rmode; !out_en_n |-> !dq_oe && write_en_n; endproperty
   a_rmode: assert property (p_rmode) else $error("bus driven during read");
   property p_ahold; !write_en_n && $past(!write_en_n) |-> $stable(mem_addr); endproperty
   a_ahold: assert property (p_ahold) else $error("address moved in strobe");
   property p_dhold; !write_en_n && $past(!write_en_n) |-> $stable(dq_out); endproperty
   a_dhold: assert property (p_dhold) else $error("data moved in strobe");
   property p_width; $rose(write_en_n) |-> wl == STROBE_CYC + 2; endproperty
   a_width: assert property (p_width) else $error("write strobe width");
   property p_cefirst; $fell(write_en_n) |-> $past(!chip_en_n); endproperty
   a_cefirst: assert property (p_cefirst) else $error("chip enable late");
   property p_release; $rose(write_en_n) |-> ##[0:4] chip_en_n && !dq_oe; endproperty
   a_release: assert property (p_release) else $error("bus not released");
   property p_bus; hreadyout && !hresp; endproperty
   a_bus: assert property (p_bus) else $error("bus answer not okay");
   property p_nowr; !ready_busy_od && $past(!ready_busy_od, 3) |-> !$fell(write_en_n); endproperty
   a_nowr: assert property (p_nowr) else $error("write while busy");
endmodule
bind eeprom_host eeprom_host_props #(.STROBE_CYC(STROBE_CYC)) u_props (.hclk, .hresetn,
   .hreadyout, .hresp, .mem_addr, .dq_out, .dq_oe, .chip_en_n, .out_en_n, .write_en_n,
   .ready_busy_od);

/* eeprom_model.sv */
// behavioural parallel eeprom answering the host pins
`timescale 1ns/1ns
`include "eeprom_ctrl_map.vh"
module eeprom_model #(
   parameter PAGE_NS = 2000,
   parameter PROG_NS = 5000
)(
   input  wire [12:0] mem_addr,
   input  wire [7:0]  dq_out,
   input  wire        dq_oe,
   input  wire        chip_en_n,
   input  wire        out_en_n,
   input  wire        write_en_n,
   output wire [7:0]  dq_in,
   output wire        ready_busy_od
);
   localparam [20:0] k1 = {`SEQ_A1, `SEQ_D1};
   localparam [20:0] k2 = {`SEQ_A2, `SEQ_D2};
   reg [7:0]  mem [0:8191];
   reg [20:0] pq [$];
   reg [12:0] al;
   reg [7:0]  lastv = 8'h00;
   reg        busy = 0;
   reg        prot = 0;
   reg        tog = 0;
   reg        l7 = 0;
   time       tl = 0;
   wire       wa = !chip_en_n && !write_en_n && out_en_n;
   wire       re = !chip_en_n && !out_en_n && write_en_n;
   wire [7:0] rv = busy ? {~l7, tog, 6'h20} : mem[mem_addr];
   wire [7:0] drv = dq_oe ? dq_out : rv;
   // undriven bus shows the inverse of its last level
   assign dq_in = (dq_oe || re) ? drv : ~lastv;
   assign ready_busy_od = !busy;
   initial foreach (mem[i]) mem[i] = 8'hff;
   always @(drv or dq_oe or re)
      if (dq_oe || re)
         lastv = drv;
   // address on the later fall, data on the earlier rise
   always @(posedge wa)
      al = mem_addr;
   always @(negedge wa)
      if (!busy)
      begin
         pq.push_back({al, dq_out});
         tl = $time;
      end
   always @(negedge re)
      if (busy)
         tog = !tog;
   // page timer, then self-timed programming
   initial forever
   begin
      #50;
      if (pq.size() > 0 && $time - tl >= PAGE_NS)
      begin
         busy = 1;
         tog = 0;
         l7 = pq[pq.size() - 1][7];
         #PROG_NS;
         if (pq.size() == 3 && pq[0] == k1 && pq[1] == k2 && pq[2] == {`SEQ_A1, `SEQ_ON})
            prot = 1;
         else if (pq.size() == 6 && pq[0] == k1 && pq[1] == k2 && pq[3] == k1 && pq[4] == k2
            && pq[2] == {`SEQ_A1, `SEQ_OFF1} && pq[5] == {`SEQ_A1, `SEQ_OFF6})
            prot = 0;
         else if (!prot)
            foreach (pq[i]) mem[pq[i][20:8]] = pq[i][7:0];
         pq.delete();
         busy = 0;
      end
   end
endmodule

/* eeprom_host_tb.sv */
// self-checking bench for the eeprom host controller
`timescale 1ns/1ns
`include "eeprom_ctrl_map.vh"
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
   $display("MISMATCH %s exp %h got %h", n, e, a); end end
module eeprom_host_tb;
   reg         hclk = 0;
   reg         hresetn = 0;
   reg         hsel = 0;
   reg  [31:0] haddr = 0;
   reg  [1:0]  htrans = 0;
   reg         hwrite = 0;
   reg  [2:0]  hsize = 3'h2;
   reg  [31:0] hwdata = 0;
   wire [31:0] hrdata;
   wire        hreadyout, hresp, dq_oe, chip_en_n, out_en_n, write_en_n, ready_busy_od;
   wire [12:0] mem_addr;
   wire [7:0]  dq_out, dq_in;
   integer     mismatches = 0;
   integer     comparisons = 0;
   reg  [7:0]  ref_mem [0:8191];
   reg         ref_prot = 0;
   reg  [31:0] s;
   reg  [12:0] a;
   always #25 hclk = ~hclk;
   eeprom_host #(.INTERVAL_CYC(50), .WRITE_CYC(500), .STROBE_CYC(4)) uut (.hclk, .hresetn,
      .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
      .hreadyout, .hresp, .mem_addr, .dq_out, .dq_oe, .dq_in, .chip_en_n, .out_en_n,
      .write_en_n, .ready_busy_od);
   eeprom_model #(.PAGE_NS(2000), .PROG_NS(5000)) dev (.mem_addr, .dq_out, .dq_oe,
      .chip_en_n, .out_en_n, .write_en_n, .dq_in, .ready_busy_od);
   // one single ahb transfer, waits for hready in both phases
   task ahb(input [7:0] ad, input w, input [31:0] wd, output [31:0] r);
   begin
      hsel <= 1'b1;
      haddr <= {24'h0, ad};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   end
   endtask
   // poll status until the masked busy and page open bits clear
   task wait_mask(input [1:0] m);
      integer n;
   begin
      n = 0;
      do
      begin
         ahb(8'h0c, 1'b0, 32'h0, s);
         n++;
      end
      while ((s[1:0] & m) !== 2'b00 && n < 2000);
      `CHK("idle", 1'b1, n < 2000)
   end
   endtask
   // poll status until neither busy nor page open
   task wait_idle;
      wait_mask(2'b11);
   endtask
   task wbyte(input [12:0] wa, input [7:0] wd);
   begin
      ahb(8'h04, 1'b1, {19'h0, wa}, s);
      ahb(8'h08, 1'b1, {24'h0, wd}, s);
      ahb(8'h00, 1'b1, {29'h0, `CMD_WRITE}, s);
      wait_mask(2'b01);
      if (!ref_prot)
         ref_mem[wa] = wd;
   end
   endtask
   task chk_byte(input [12:0] ra);
   begin
      ahb(8'h04, 1'b1, {19'h0, ra}, s);
      ahb(8'h00, 1'b1, {29'h0, `CMD_READ}, s);
      wait_idle;
      `CHK("rdata", ref_mem[ra], s[15:8])
      `CHK("toggle", ref_mem[ra][6], s[3])
   end
   endtask
   task cmd(input [2:0] c);
      ahb(8'h00, 1'b1, {29'h0, c}, s);
   endtask
   task final_report;
   begin
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   end
   endtask
   // watchdog against a hung handshake
   initial
   begin
      #2000000;
      mismatches++;
      final_report;
   end
   initial
   begin
      foreach (ref_mem[i]) ref_mem[i] = 8'hff;
      s = $urandom(79);
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(8'h0c, 1'b0, 32'h0, s);
      `CHK("status", 32'h4, s)
      ahb(8'h10, 1'b0, 32'h0, s);
      `CHK("unmapped", 32'h0, s)
      $display("test reset done");
      // single bytes ended by the page timer
      repeat (3)
      begin
         a = 13'($urandom);
         wbyte(a, 8'($urandom));
         wait_idle;
         chk_byte(a);
      end
      $display("test byte done");
      // full page of 64 bytes then commit
      a = {7'($urandom), 6'h00};
      for (int i = 0; i < 64; i++)
         wbyte(a + 13'(i), 8'($urandom));
      cmd(`CMD_COMMIT);
      s = 32'h4;
      for (int k = 0; k < 200 && s[2]; k++)
         ahb(8'h0c, 1'b0, 32'h0, s);
      `CHK("busy", 2'b01, {s[2], s[0]})
      wait_idle;
      chk_byte(a);
      chk_byte(a + 13'd63);
      chk_byte(a + 13'd17);
      $display("test page done");
      // protected write leaves the array, unprotected write lands
      a = 13'($urandom);
      cmd(`CMD_PROT_ON);
      wait_idle;
      ref_prot = 1;
      wbyte(a, ~ref_mem[a]);
      wait_idle;
      chk_byte(a);
      cmd(`CMD_PROT_OFF);
      wait_idle;
      ref_prot = 0;
      wbyte(a, 8'h3c);
      wait_idle;
      chk_byte(a);
      $display("test protect done");
      final_report;
   end
endmodule
